// file: logic/pmw_ctrl.v
// Purpose: power mode, halt and wake-up sequencing
// Assumes: all inputs synchronous to i_core_clk; clocks gated downstream
// Notes:   outputs are enables for clock gates, not clocks themselves
`timescale 1ns/1ns
`include "pmw_consts.vh"
module pmw_ctrl #(
  parameter NPIN = 8,
  parameter NINT = 4
) (
  input  wire                 i_core_clk,
  input  wire                 i_rst,
  input  wire                 i_high_clock_select,
  input  wire [`PMW_CKS_W-1:0] i_clock_divider_field,
  input  wire                 i_idle_select,
  input  wire                 i_idle_clock_keep,
  input  wire                 i_wdt_enable,
  input  wire                 i_low_osc_stable,
  input  wire                 i_high_osc_stable,
  input  wire                 i_halt,
  input  wire                 i_clear_watchdog_instruction,
  input  wire                 i_ext_reset_wake,
  input  wire                 i_wdt_overflow,
  input  wire [NPIN-1:0]      i_port_a,
  input  wire [NPIN-1:0]      i_port_a_wake_enable,
  input  wire [NINT-1:0]      i_int_req,
  input  wire [NINT-1:0]      i_int_enable,
  input  wire                 i_stack_full,
  output reg                  o_low_osc_ready_ff,
  output reg                  o_high_osc_ready_ff,
  output reg                  o_high_osc_on_ff,
  output reg  [`PMW_SEL_W-1:0] o_sys_clk_sel_ff,
  output reg  [`PMW_CKS_W-1:0] o_div_sel_ff,
  output reg                  o_sys_clk_en_ff,
  output reg                  o_div16_en_ff,
  output reg                  o_div64_en_ff,
  output reg                  o_tb_clk_en_ff,
  output reg                  o_wdt_clk_en_ff,
  output reg                  o_wdt_clear_ff,
  output reg                  o_cpu_run_ff,
  output reg                  o_power_down_flag_ff,
  output reg                  o_watchdog_timeout_flag_ff,
  output reg                  o_wdt_reset_ff,
  output reg                  o_int_take_ff,
  output reg  [`PMW_ST_W-1:0] o_state_ff
);
  reg  [`PMW_ST_W-1:0] state_ff;
  reg  [`PMW_ST_W-1:0] nxt_state;
  reg                  slow_ff;
  reg                  nxt_slow;
  reg                  int_wake_ff;
  wire [`PMW_DIV_W-1:0] div_cnt;
  wire                 pin_wake;
  wire                 int_wake;
  wire                 want_slow;
  wire                 in_low;
  wire                 halt_go;
  wire                 wake;
  wire                 int_serve;

  // want_slow: select low source, else the high clock, direct or divided
  assign want_slow = ~i_high_clock_select &
                     ((i_clock_divider_field == `PMW_CKS_LOW0) |
                      (i_clock_divider_field == `PMW_CKS_LOW1));
  assign in_low    = (state_ff != `PMW_ST_RUN) &
                     (state_ff != `PMW_ST_RESTART);
  assign halt_go   = i_halt & (state_ff == `PMW_ST_RUN);
  assign wake      = in_low & (pin_wake | int_wake | i_wdt_overflow);
  assign int_serve = |(i_int_req & i_int_enable) & ~i_stack_full;

  pmw_clk_div #(
    .W (`PMW_DIV_W)
  ) u_div (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_run      (o_high_osc_on_ff),
    .o_cnt_ff   (div_cnt)
  );

  pmw_wake_detect #(
    .NPIN (NPIN),
    .NINT (NINT)
  ) u_wake (
    .i_core_clk    (i_core_clk),
    .i_rst         (i_rst),
    .i_arm         (halt_go),
    .i_pins        (i_port_a),
    .i_pin_wake_en (i_port_a_wake_enable),
    .i_int_req     (i_int_req),
    .o_pin_wake_ff (pin_wake),
    .o_int_wake_ff (int_wake)
  );

  // switch to slow waits for the low oscillator; switch back to high takes effect at once
  always @* begin
    nxt_slow = slow_ff;
    if (want_slow & i_low_osc_stable) begin
      nxt_slow = 1'b1;
    end else if (~want_slow) begin
      nxt_slow = 1'b0;
    end
  end

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      `PMW_ST_RUN: begin
        if (i_halt) begin
          if (~i_idle_select) begin
            nxt_state = i_wdt_enable ? `PMW_ST_SLPWD
                                     : `PMW_ST_DEEP;
          end else begin
            nxt_state = i_idle_clock_keep ? `PMW_ST_IDLE_CLOCK_ON_STATE
                                          : `PMW_ST_IDLE_CLOCK_OFF_STATE;
          end
        end
      end
      `PMW_ST_DEEP, `PMW_ST_SLPWD, `PMW_ST_IDLE_CLOCK_OFF_STATE, `PMW_ST_IDLE_CLOCK_ON_STATE: begin
        if (wake) begin
          nxt_state = `PMW_ST_RESTART;
        end
      end
      `PMW_ST_RESTART: begin
        // hold fetch until the selected source is stable
        if (slow_ff ? i_low_osc_stable : i_high_osc_stable) begin
          nxt_state = `PMW_ST_RUN;
        end
      end
      default: begin
        nxt_state = `PMW_ST_RUN;
      end
    endcase
    // reset wake overrides every state: straight to run, skipping restart and the oscillator wait
    if (i_ext_reset_wake) begin
      nxt_state = `PMW_ST_RUN;
    end
  end

  always @(posedge i_core_clk) begin
    if (i_rst) begin
      state_ff                   <= `PMW_ST_RUN;
      slow_ff                    <= 1'b0;
      int_wake_ff                <= 1'b0;
      o_state_ff                 <= `PMW_ST_RUN;
      o_low_osc_ready_ff         <= 1'b0;
      o_high_osc_ready_ff        <= 1'b0;
      o_high_osc_on_ff           <= 1'b1;
      o_sys_clk_sel_ff           <= `PMW_SEL_HIGH;
      o_div_sel_ff               <= `PMW_CKS_LOW0;
      o_sys_clk_en_ff            <= 1'b1;
      o_div16_en_ff              <= 1'b0;
      o_div64_en_ff              <= 1'b0;
      o_tb_clk_en_ff             <= 1'b1;
      o_wdt_clk_en_ff            <= 1'b1;
      o_wdt_clear_ff             <= 1'b0;
      o_cpu_run_ff               <= 1'b1;
      o_power_down_flag_ff       <= 1'b0;
      o_watchdog_timeout_flag_ff <= 1'b0;
      o_wdt_reset_ff             <= 1'b0;
      o_int_take_ff              <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      slow_ff     <= nxt_slow;
      o_state_ff  <= nxt_state;
      // keep the interrupt cause until restart ends, however long the settle takes
      int_wake_ff <= (wake & int_wake) |
                     (int_wake_ff & (state_ff == `PMW_ST_RESTART));
      o_low_osc_ready_ff  <= i_low_osc_stable;
      o_high_osc_ready_ff <= i_high_osc_stable & ~nxt_slow;

      // high oscillator: off in slow mode, deep sleep, sleep with watchdog, or idle_clock_off_state
      o_high_osc_on_ff <= ~nxt_slow &
                          (nxt_state != `PMW_ST_DEEP) &
                          (nxt_state != `PMW_ST_SLPWD) &
                          (nxt_state != `PMW_ST_IDLE_CLOCK_OFF_STATE);
      if (nxt_slow) begin
        o_sys_clk_sel_ff <= `PMW_SEL_LOW;
      end else if (i_high_clock_select) begin
        o_sys_clk_sel_ff <= `PMW_SEL_HIGH;
      end else begin
        o_sys_clk_sel_ff <= `PMW_SEL_DIV;
      end
      o_div_sel_ff  <= i_clock_divider_field;
      // divided taps stop with the oscillator
      o_div16_en_ff <= o_high_osc_on_ff & div_cnt[`PMW_DIV16_BIT];
      o_div64_en_ff <= o_high_osc_on_ff & div_cnt[`PMW_DIV64_BIT];

      o_sys_clk_en_ff <= (nxt_state == `PMW_ST_RUN) |
                         (nxt_state == `PMW_ST_RESTART) |
                         (nxt_state == `PMW_ST_IDLE_CLOCK_ON_STATE);
      o_tb_clk_en_ff  <= (nxt_state != `PMW_ST_DEEP) &
                         (nxt_state != `PMW_ST_SLPWD);
      o_wdt_clk_en_ff <= (nxt_state != `PMW_ST_DEEP);
      o_cpu_run_ff    <= (nxt_state == `PMW_ST_RUN);

      // halt and clear-watchdog both zero the counter
      o_wdt_clear_ff  <= halt_go | i_clear_watchdog_instruction;
      // watchdog wake restarts pc and sp only
      o_wdt_reset_ff  <= in_low & i_wdt_overflow;
      // pending wake interrupt serviced at the restart-to-run step only if enabled and stack free then
      o_int_take_ff   <= (state_ff == `PMW_ST_RESTART) &
                         (nxt_state == `PMW_ST_RUN) &
                         int_wake_ff & int_serve;

      // set wins: halt in same cycle as clear-watchdog sets flag
      if (halt_go) begin
        o_power_down_flag_ff <= 1'b1;
      end else if (i_clear_watchdog_instruction) begin
        o_power_down_flag_ff <= 1'b0;
      end
      if (in_low & i_wdt_overflow) begin
        o_watchdog_timeout_flag_ff <= 1'b1;
      end else if (halt_go) begin
        o_watchdog_timeout_flag_ff <= 1'b0;
      end
    end
  end
endmodule

// file: pkg/pmw_consts.vh
// Purpose: constants for the power mode and wake-up controller
// Assumes: included by bare name from logic files
// Notes:   definitions only
`ifndef PMW_CONSTS_VH
`define PMW_CONSTS_VH
`define PMW_CKS_W        3
`define PMW_CKS_LOW0     3'h0
`define PMW_CKS_LOW1     3'h1
`define PMW_CKS_DIV64    3'h2
`define PMW_CKS_DIV32    3'h3
`define PMW_CKS_DIV16    3'h4
`define PMW_CKS_DIV8     3'h5
`define PMW_CKS_DIV4     3'h6
`define PMW_CKS_DIV2     3'h7
`define PMW_DIV_W        6
`define PMW_DIV16_BIT    3
`define PMW_DIV64_BIT    5
`define PMW_ST_W         3
`define PMW_ST_RUN       3'h0
`define PMW_ST_DEEP      3'h1
`define PMW_ST_SLPWD     3'h2
`define PMW_ST_IDLE_CLOCK_OFF_STATE     3'h3
`define PMW_ST_IDLE_CLOCK_ON_STATE     3'h4
`define PMW_ST_RESTART   3'h5
`define PMW_SEL_W        2
`define PMW_SEL_HIGH     2'h0
`define PMW_SEL_DIV      2'h1
`define PMW_SEL_LOW      2'h2
`define PMW_SEL_NONE     2'h3
`endif

// file: logic/pmw_clk_div.v
// Purpose: free-running divider of the high-speed clock
// Assumes: i_run low stops and clears the chain
// Notes:   taps give divided-by-2 through divided-by-64 enables
`timescale 1ns/1ns
`include "pmw_consts.vh"
module pmw_clk_div #(
  parameter W = `PMW_DIV_W
) (
  input  wire         i_core_clk,
  input  wire         i_rst,
  input  wire         i_run,
  output reg  [W-1:0] o_cnt_ff
);
  reg [W-1:0] nxt_cnt;
  always @* begin
    nxt_cnt = i_run ? o_cnt_ff + {{(W-1){1'b0}}, 1'b1} : {W{1'b0}};
  end
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_cnt_ff <= {W{1'b0}};
    end else begin
      o_cnt_ff <= nxt_cnt;
    end
  end
endmodule

// file: logic/pmw_wake_detect.v
// Purpose: port a falling-edge wake and interrupt wake qualification
// Assumes: pins synchronous; i_arm pulses on halt entry
// Notes:   interrupts already pending at entry are masked
`timescale 1ns/1ns
module pmw_wake_detect #(
  parameter NPIN = 8,
  parameter NINT = 4
) (
  input  wire            i_core_clk,
  input  wire            i_rst,
  input  wire            i_arm,
  input  wire [NPIN-1:0] i_pins,
  input  wire [NPIN-1:0] i_pin_wake_en,
  input  wire [NINT-1:0] i_int_req,
  output reg             o_pin_wake_ff,
  output reg             o_int_wake_ff
);
  reg  [NPIN-1:0] pins_ff;
  reg  [NINT-1:0] int_mask_ff;
  wire [NPIN-1:0] fall;
  genvar g;
  generate
    for (g = 0; g < NPIN; g = g + 1) begin : g_pin
      assign fall[g] = pins_ff[g] & ~i_pins[g] & i_pin_wake_en[g];
    end
  endgenerate
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      pins_ff       <= {NPIN{1'b1}};
      int_mask_ff   <= {NINT{1'b0}};
      o_pin_wake_ff <= 1'b0;
      o_int_wake_ff <= 1'b0;
    end else begin
      pins_ff       <= i_pins;
      // requests set before entry cannot wake until they drop and rise again
      if (i_arm) begin
        int_mask_ff <= i_int_req;
      end else begin
        int_mask_ff <= int_mask_ff & i_int_req;
      end
      o_pin_wake_ff <= |fall;
      o_int_wake_ff <= |(i_int_req & ~int_mask_ff) & ~i_arm;
    end
  end
endmodule

// file: testbench/pmw_osc_model.sv
// Purpose: oscillator side of the power mode controller
// Assumes: high oscillator settles only while enabled
// Notes:   i_slow stretches settling to stress the switch-back
`timescale 1ns/1ns
module pmw_osc_model (
  input  wire i_core_clk,
  input  wire i_rst,
  input  wire i_high_on,
  input  wire i_slow,
  output reg  o_low_stable,
  output reg  o_high_stable
);
  reg [3:0] hcnt;
  reg [1:0] lcnt;
  // counters saturate so stable never drops while enabled
  always @(posedge i_core_clk) begin
    if (i_rst || !i_high_on) begin
      hcnt <= 4'h0;
      o_high_stable <= 1'b0;
    end else begin
      if (hcnt != 4'hf)
        hcnt <= hcnt + 4'h1;
      o_high_stable <= hcnt >= (i_slow ? 4'hc : 4'h2);
    end
    if (i_rst) begin
      lcnt <= 2'h0;
      o_low_stable <= 1'b0;
    end else begin
      if (lcnt != 2'h3)
        lcnt <= lcnt + 2'h1;
      o_low_stable <= lcnt == 2'h3;
    end
  end
endmodule

// file: testbench/pmw_ctrl_monitor.sv
// Purpose: port-level assertions for the power mode controller
// Assumes: bound to pmw_ctrl, sees its ports only
// Notes:   latencies follow the hand-over timing
`timescale 1ns/1ns
module pmw_ctrl_monitor #(
  parameter NPIN = 8
) (
  input wire            i_core_clk,
  input wire            i_rst,
  input wire            i_high_clock_select,
  input wire [2:0]      i_clock_divider_field,
  input wire            i_idle_select,
  input wire            i_idle_clock_keep,
  input wire            i_wdt_enable,
  input wire            i_low_osc_stable,
  input wire            i_high_osc_stable,
  input wire            i_halt,
  input wire            i_ext_reset_wake,
  input wire            i_wdt_overflow,
  input wire [NPIN-1:0] i_port_a,
  input wire [NPIN-1:0] i_port_a_wake_enable,
  input wire            o_high_osc_on_ff,
  input wire [1:0]      o_sys_clk_sel_ff,
  input wire [2:0]      o_div_sel_ff,
  input wire            o_sys_clk_en_ff,
  input wire            o_div16_en_ff,
  input wire            o_div64_en_ff,
  input wire            o_tb_clk_en_ff,
  input wire            o_wdt_clk_en_ff,
  input wire            o_wdt_clear_ff,
  input wire            o_cpu_run_ff,
  input wire            o_power_down_flag_ff,
  input wire            o_watchdog_timeout_flag_ff,
  input wire            o_wdt_reset_ff,
  input wire [2:0]      o_state_ff
);
  wire go = o_state_ff == 3'h0 && i_halt && !i_ext_reset_wake;
  wire lp = o_state_ff >= 3'h1 && o_state_ff <= 3'h4;
  wire sel_ok = (o_sys_clk_sel_ff == 2'h2) ? i_low_osc_stable
                                           : i_high_osc_stable;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  AST_DEEP: assert property (go && !i_idle_select && !i_wdt_enable |=>
    o_state_ff == 3'h1 && !o_wdt_clk_en_ff && !o_sys_clk_en_ff)
    else $error("deep sleep entry wrong");
  AST_SLPWD: assert property (go && !i_idle_select && i_wdt_enable |=>
    o_state_ff == 3'h2 && o_wdt_clk_en_ff && !o_tb_clk_en_ff)
    else $error("sleep with watchdog entry wrong");
  AST_IDLE_CLOCK_OFF_STATE: assert property (go && i_idle_select && !i_idle_clock_keep |=>
    o_state_ff == 3'h3 && !o_sys_clk_en_ff && o_tb_clk_en_ff)
    else $error("idle clock off entry wrong");
  AST_IDLE_CLOCK_ON_STATE: assert property (go && i_idle_select && i_idle_clock_keep |=>
    o_state_ff == 3'h4 && o_sys_clk_en_ff && o_tb_clk_en_ff)
    else $error("idle clock on entry wrong");
  AST_HALT_FLAGS: assert property (go |=> o_power_down_flag_ff &&
    !o_watchdog_timeout_flag_ff && o_wdt_clear_ff && !o_cpu_run_ff
    ##1 !o_wdt_clear_ff) else $error("halt flags or clear pulse wrong");
  AST_SLOW: assert property ((o_state_ff == 3'h0 && !i_high_clock_select
    && i_clock_divider_field <= 3'h1 && i_low_osc_stable) [*4] |->
    o_sys_clk_sel_ff == 2'h2 && !o_high_osc_on_ff && !o_div16_en_ff
    && !o_div64_en_ff) else $error("slow mode not taken");
  AST_FAST: assert property ((o_state_ff == 3'h0 && i_high_osc_stable &&
    (i_high_clock_select || i_clock_divider_field >= 3'h2)) [*3] |->
    o_sys_clk_sel_ff == ($past(i_high_clock_select) ? 2'h0 : 2'h1) &&
    o_div_sel_ff == $past(i_clock_divider_field) && o_high_osc_on_ff)
    else $error("fast mode not taken");
  AST_PIN_WAKE: assert property (lp && $past(lp) && !i_ext_reset_wake &&
    |($past(i_port_a) & ~i_port_a & i_port_a_wake_enable) |->
    ##[1:3] (o_state_ff == 3'h5 || o_state_ff == 3'h0))
    else $error("pin fall did not wake");
  AST_RESUME: assert property (o_state_ff == 3'h0 &&
    $past(o_state_ff) == 3'h5 && !$past(i_ext_reset_wake) |->
    $past(sel_ok) && o_cpu_run_ff) else $error("fetch before clock stable");
  AST_WDT_WAKE: assert property (o_state_ff >= 3'h2 && lp &&
    i_wdt_overflow && !i_ext_reset_wake |->
    ##[1:4] (o_wdt_reset_ff && o_watchdog_timeout_flag_ff))
    else $error("watchdog wake missing");
  cover property (o_state_ff == 3'h1);
  cover property (o_wdt_reset_ff);
  cover property (o_state_ff == 3'h5 ##1 o_state_ff == 3'h0);
endmodule
bind pmw_ctrl pmw_ctrl_monitor #(.NPIN(NPIN)) pmw_ctrl_monitor_inst (
  .i_core_clk, .i_rst, .i_high_clock_select, .i_clock_divider_field,
  .i_idle_select, .i_idle_clock_keep, .i_wdt_enable, .i_low_osc_stable,
  .i_high_osc_stable, .i_halt, .i_ext_reset_wake, .i_wdt_overflow,
  .i_port_a, .i_port_a_wake_enable, .o_high_osc_on_ff, .o_sys_clk_sel_ff,
  .o_div_sel_ff, .o_sys_clk_en_ff, .o_div16_en_ff, .o_div64_en_ff,
  .o_tb_clk_en_ff, .o_wdt_clk_en_ff, .o_wdt_clear_ff, .o_cpu_run_ff,
  .o_power_down_flag_ff, .o_watchdog_timeout_flag_ff, .o_wdt_reset_ff,
  .o_state_ff);

// file: testbench/tb_pmw_ctrl.sv
// Purpose: self-checking bench for the power mode controller
// Assumes: inputs change on the falling clock edge
// Notes:   oscillator settling comes from the partner model
`timescale 1ns/1ns
`include "pmw_consts.vh"
module tb_pmw_ctrl;
  reg        clk, rst, hcs, idl, keep, wde, halt, clrw, ext, ovf;
  reg        sfull, slow, took;
  reg  [2:0] cks;
  reg  [7:0] pa, pawe;
  reg  [3:0] ireq, ien;
  wire       low_st, high_st, low_rdy, high_rdy, high_on, sys, tbe;
  wire       cpu, power_down_flag, tof, wrst, take;
  wire [1:0] sel;
  wire [2:0] dsel, st;
  integer    failures, comparisons, cycles, n, b, k;
  pmw_ctrl pmw_ctrl_inst (
    .i_core_clk(clk), .i_rst(rst), .i_high_clock_select(hcs),
    .i_clock_divider_field(cks), .i_idle_select(idl),
    .i_idle_clock_keep(keep), .i_wdt_enable(wde),
    .i_low_osc_stable(low_st), .i_high_osc_stable(high_st),
    .i_halt(halt), .i_clear_watchdog_instruction(clrw),
    .i_ext_reset_wake(ext), .i_wdt_overflow(ovf), .i_port_a(pa),
    .i_port_a_wake_enable(pawe), .i_int_req(ireq), .i_int_enable(ien),
    .i_stack_full(sfull), .o_low_osc_ready_ff(low_rdy),
    .o_high_osc_ready_ff(high_rdy), .o_high_osc_on_ff(high_on),
    .o_sys_clk_sel_ff(sel), .o_div_sel_ff(dsel), .o_sys_clk_en_ff(sys),
    .o_div16_en_ff(), .o_div64_en_ff(), .o_tb_clk_en_ff(tbe),
    .o_wdt_clk_en_ff(), .o_wdt_clear_ff(), .o_cpu_run_ff(cpu),
    .o_power_down_flag_ff(power_down_flag), .o_watchdog_timeout_flag_ff(tof),
    .o_wdt_reset_ff(wrst), .o_int_take_ff(take), .o_state_ff(st));
  pmw_osc_model pmw_osc_model_inst (.i_core_clk(clk), .i_rst(rst),
    .i_high_on(high_on), .i_slow(slow), .o_low_stable(low_st),
    .o_high_stable(high_st));
  always #2 clk = ~clk;
  task finish_test;
    begin
      $display("failures=%0d comparisons=%0d", failures, comparisons);
      if (failures == 0 && comparisons > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // hang guard, well above the few hundred cycles used
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      failures = failures + 1;
      finish_test;
    end
  end
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  function [2:0] exp_st(input i, input c, input w);
    exp_st = i ? (c ? `PMW_ST_IDLE_CLOCK_ON_STATE : `PMW_ST_IDLE_CLOCK_OFF_STATE)
               : (w ? `PMW_ST_SLPWD : `PMW_ST_DEEP);
  endfunction
  // tail cycles catch a late interrupt vector pulse
  task wait_st(input [2:0] s);
    begin
      k = 0;
      while (st !== s && k < 60) begin
        @(negedge clk);
        took = took | take;
        k = k + 1;
      end
      repeat (3) begin
        @(negedge clk);
        took = took | take;
      end
      chk(st, s);
    end
  endtask
  task do_halt(input i, input c, input w);
    begin
      idl = i;
      keep = c;
      wde = w;
      halt = 1'b1;
      @(negedge clk);
      halt = 1'b0;
      chk(st, exp_st(i, c, w));
      chk({sys, tbe}, i ? {c, 1'b1} : 2'b00);
      chk({power_down_flag, tof, cpu}, 3'h4);
    end
  endtask
  initial begin
    // fast mode after reset, as the select bit powers up high
    {clk, hcs, idl, keep, wde, halt, clrw, ext, ovf} = 9'h080;
    {sfull, slow, took, rst, cks, ireq, ien} = 15'h0800;
    pa = 8'hff;
    pawe = 8'h00;
    {failures, comparisons, cycles} = 0;
    n = $urandom(32'ha5f5_fd90);
    repeat (5) @(negedge clk);
    rst = 1'b0;
    for (n = 0; n < 8; n = n + 1) begin
      b = $urandom % 8;
      pawe = 8'h01 << b;
      do_halt(n[1], n[0], n[2] ^ n[0]);
      pa = ~(8'h01 << ((b + 1) % 8));
      repeat (4) @(negedge clk);
      chk(st, exp_st(n[1], n[0], n[2] ^ n[0]));
      pa = pa & ~pawe;
      wait_st(`PMW_ST_RUN);
      chk(cpu, 1'b1);
      pa = 8'hff;
    end
    do_halt(1'b0, 1'b0, 1'b1);
    ovf = 1'b1;
    @(negedge clk);
    ovf = 1'b0;
    for (k = 0; k < 20 && wrst !== 1'b1; k = k + 1)
      @(negedge clk);
    chk({wrst, tof, power_down_flag}, 3'h7);
    wait_st(`PMW_ST_RUN);
    clrw = 1'b1;
    @(negedge clk);
    clrw = 1'b0;
    chk(power_down_flag, 1'b0);
    ireq = 4'h1;
    ien = 4'hf;
    @(negedge clk);
    do_halt(1'b1, 1'b1, 1'b0);
    repeat (6) @(negedge clk);
    chk(st, `PMW_ST_IDLE_CLOCK_ON_STATE);
    took = 1'b0;
    ireq = 4'h0;
    @(negedge clk);
    ireq = 4'h1 << ($urandom % 4);
    wait_st(`PMW_ST_RUN);
    chk(took, 1'b1);
    for (n = 0; n < 2; n = n + 1) begin
      ireq = 4'h0;
      sfull = n[0];
      ien = n[0] ? 4'hf : 4'hb;
      took = 1'b0;
      @(negedge clk);
      do_halt(1'b0, 1'b0, 1'b0);
      ireq = 4'h4;
      wait_st(`PMW_ST_RUN);
      chk(took, 1'b0);
    end
    do_halt(1'b1, 1'b0, 1'b0);
    ext = 1'b1;
    @(negedge clk);
    ext = 1'b0;
    wait_st(`PMW_ST_RUN);
    hcs = 1'b0;
    cks = 3'($urandom % 2);
    repeat (6) @(negedge clk);
    chk({sel, high_on, low_rdy}, {`PMW_SEL_LOW, 2'b01});
    slow = 1'b1;
    cks = 3'h2;
    for (k = 0; k < 40 && high_rdy !== 1'b1; k = k + 1)
      @(negedge clk);
    chk(high_rdy, 1'b1);
    for (n = 2; n < 8; n = n + 1) begin
      cks = n[2:0];
      repeat (3) @(negedge clk);
      chk({sel, dsel}, {`PMW_SEL_DIV, cks});
    end
    hcs = 1'b1;
    repeat (3) @(negedge clk);
    chk(sel, `PMW_SEL_HIGH);
    finish_test;
  end
endmodule
